// >>> hw/pts_pkg.sv
// Package for the period timer: register map, field layout, reset values, carriers
package pts_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] PTS_OFS_CONTROL = 8'h00;
    localparam logic [7:0] PTS_OFS_PERIOD  = 8'h04;
    localparam logic [7:0] PTS_OFS_COUNT   = 8'h08;
    localparam logic [7:0] PTS_OFS_FLAGS   = 8'h0C;
    localparam logic [7:0] PTS_OFS_ENABLES = 8'h10;
    // Control field positions
    localparam int PTS_POST_LSB = 3;
    localparam int PTS_POST_MSB = 6;
    localparam int PTS_RUN_BIT  = 2;
    localparam int PTS_PRE_LSB  = 0;
    localparam int PTS_PRE_MSB  = 1;
    // Flag and enable bit position
    localparam int PTS_IRQ_BIT  = 1;
    // Reset values
    localparam logic [7:0] PTS_CONTROL_RST = 8'h00;
    localparam logic [7:0] PTS_PERIOD_RST  = 8'hFF;
    localparam logic [7:0] PTS_COUNT_RST   = 8'h00;
    // Prescaler terminal counts for 1, 4, 16, 64
    localparam logic [5:0] PTS_PRE_TC_1  = 6'h00;
    localparam logic [5:0] PTS_PRE_TC_4  = 6'h03;
    localparam logic [5:0] PTS_PRE_TC_16 = 6'h0F;
    localparam logic [5:0] PTS_PRE_TC_64 = 6'h3F;

    // Fields of the control register
    typedef struct packed {
        logic       unused;
        logic [3:0] postscale_select;
        logic       timer_run;
        logic [1:0] prescale_select;
    } pts_control_type;

    // Events that leave the timer toward its neighbours
    typedef struct packed {
        logic match_pulse;
        logic post_event;
    } pts_event_type;
endpackage : pts_pkg

// >>> hw/pts_prescaler.sv
// Prescaler: divides the instruction clock tick by 1, 4, 16 or 64
module pts_prescaler
    import pts_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic       tick_in,
    input  wire logic [1:0] prescale_select,
    // Output
    output logic            tick_out
);
    logic [5:0] count;
    logic [5:0] next_count;
    logic [5:0] terminal;

    // Terminal count and next value
    always_comb begin
        unique case (prescale_select)
            2'b00: terminal = PTS_PRE_TC_1;
            2'b01: terminal = PTS_PRE_TC_4;
            2'b10: terminal = PTS_PRE_TC_16;
            2'b11: terminal = PTS_PRE_TC_64;
        endcase
        tick_out   = tick_in && (count >= terminal);
        next_count = count;
        if (clear) begin
            next_count = 6'h00;
        end else if (tick_out) begin
            next_count = 6'h00;
        end else if (tick_in) begin
            next_count = count + 6'h01;
        end
    end

    // Register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= 6'h00;
        end else begin
            count <= next_count;
        end
    end
endmodule : pts_prescaler

// >>> hw/pts_postscaler.sv
// Postscaler: one event per (select + 1) match pulses
module pts_postscaler
    import pts_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic       match_in,
    input  wire logic [3:0] postscale_select,
    // Output
    output logic            event_out
);
    logic [3:0] count;
    logic [3:0] next_count;

    // Compare with select; wrap on event
    always_comb begin
        event_out  = match_in && (count >= postscale_select);
        next_count = count;
        if (clear) begin
            next_count = 4'h0;
        end else if (event_out) begin
            next_count = 4'h0;
        end else if (match_in) begin
            next_count = count + 4'h1;
        end
    end

    // Register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= 4'h0;
        end else begin
            count <= next_count;
        end
    end
endmodule : pts_postscaler

// >>> hw/pts_timer.sv
// Period timer top: APB registers, count/compare, prescaler and postscaler
//
// Register access over APB and the register addresses are this design's own decisions.
module pts_timer
    import pts_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device context
    input  wire logic        instr_tick,
    input  wire logic        sleep,
    // Timer outputs
    output logic             pwm_time_base,
    output logic             spi_shift_clock,
    output logic             period_match_irq_req
);
    pts_control_type control;
    pts_control_type next_control;
    logic [7:0]      period_compare_value;
    logic [7:0]      next_period_compare_value;
    logic [7:0]      period_timer_count;
    logic [7:0]      next_period_timer_count;
    logic            period_match_irq_flag;
    logic            next_period_match_irq_flag;
    logic            period_match_irq_enable;
    logic            next_period_match_irq_enable;
    logic            shift_toggle;
    logic            next_shift_toggle;
    logic [31:0]     next_prdata;
    logic            next_pready;
    logic            next_pslverr;
    logic            next_irq_req;
    logic            next_pwm;

    logic            access;
    logic            wr;
    logic            wr_count;
    logic            wr_control;
    logic            scaler_clear;
    logic            count_tick;
    logic            pre_in;
    logic            equal;
    pts_event_type   events;

    // APB access phase; one wait state via pready so every answer is registered
    assign access       = psel && penable && !pready;
    assign wr           = access && pwrite;
    assign wr_count     = wr && (paddr == PTS_OFS_COUNT);
    assign wr_control   = wr && (paddr == PTS_OFS_CONTROL);
    assign scaler_clear = wr_count || wr_control;
    // Sleep gates the tick, so count and period simply hold
    assign pre_in       = instr_tick && control.timer_run && !sleep;
    assign equal        = (period_timer_count == period_compare_value);

    // Clock prescaler
    pts_prescaler u_prescaler (
        .core_clk        (core_clk),
        .rst             (rst),
        .clear           (scaler_clear),
        .tick_in         (pre_in),
        .prescale_select (control.prescale_select),
        .tick_out        (count_tick)
    );

    // Match postscaler
    pts_postscaler u_postscaler (
        .core_clk         (core_clk),
        .rst              (rst),
        .clear            (scaler_clear),
        .match_in         (events.match_pulse),
        .postscale_select (control.postscale_select),
        .event_out        (events.post_event)
    );

    // Match is taken on a counted tick while count equals period
    assign events.match_pulse = count_tick && equal;

    // Timer state and registers
    always_comb begin
        next_control                 = control;
        next_period_compare_value    = period_compare_value;
        next_period_timer_count      = period_timer_count;
        next_period_match_irq_enable = period_match_irq_enable;
        next_period_match_irq_flag   = period_match_irq_flag;
        next_shift_toggle            = shift_toggle;
        // Counting: reload zero after a match, otherwise increment
        if (count_tick) begin
            if (equal) begin
                next_period_timer_count = 8'h00;
            end else begin
                next_period_timer_count = period_timer_count + 8'h01;
            end
        end
        // Shift clock toggles on each unscaled match
        if (events.match_pulse) begin
            next_shift_toggle = !shift_toggle;
        end
        // Software writes
        if (wr) begin
            unique case (paddr)
                PTS_OFS_CONTROL: begin
                    next_control        = pts_control_type'(pwdata[7:0]);
                    next_control.unused = 1'b0;
                end
                PTS_OFS_PERIOD: begin
                    next_period_compare_value = pwdata[7:0];
                end
                PTS_OFS_COUNT: begin
                    next_period_timer_count = pwdata[7:0];
                end
                PTS_OFS_FLAGS: begin
                    if (!pwdata[PTS_IRQ_BIT]) begin
                        next_period_match_irq_flag = 1'b0;
                    end
                end
                PTS_OFS_ENABLES: begin
                    next_period_match_irq_enable = pwdata[PTS_IRQ_BIT];
                end
                default: begin
                end
            endcase
        end
        // Set wins over a software clear in the same cycle
        if (events.post_event) begin
            next_period_match_irq_flag = 1'b1;
        end
    end

    // APB answer
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pready  = access;
        next_pslverr = 1'b0;
        if (access) begin
            unique case (paddr)
                PTS_OFS_CONTROL: next_prdata[7:0] = control;
                PTS_OFS_PERIOD:  next_prdata[7:0] = period_compare_value;
                PTS_OFS_COUNT:   next_prdata[7:0] = period_timer_count;
                PTS_OFS_FLAGS:   next_prdata[PTS_IRQ_BIT] = period_match_irq_flag;
                PTS_OFS_ENABLES: next_prdata[PTS_IRQ_BIT] = period_match_irq_enable;
                default:         next_pslverr = 1'b1;
            endcase
        end
        next_irq_req = next_period_match_irq_flag && next_period_match_irq_enable;
        next_pwm     = events.match_pulse;
    end

    // Registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control                 <= pts_control_type'(PTS_CONTROL_RST);
            period_compare_value    <= PTS_PERIOD_RST;
            period_timer_count      <= PTS_COUNT_RST;
            period_match_irq_flag   <= 1'b0;
            period_match_irq_enable <= 1'b0;
            shift_toggle            <= 1'b0;
            prdata                  <= 32'h0000_0000;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
            period_match_irq_req    <= 1'b0;
            pwm_time_base           <= 1'b0;
            spi_shift_clock         <= 1'b0;
        end else begin
            control                 <= next_control;
            period_compare_value    <= next_period_compare_value;
            period_timer_count      <= next_period_timer_count;
            period_match_irq_flag   <= next_period_match_irq_flag;
            period_match_irq_enable <= next_period_match_irq_enable;
            shift_toggle            <= next_shift_toggle;
            prdata                  <= next_prdata;
            pready                  <= next_pready;
            pslverr                 <= next_pslverr;
            period_match_irq_req    <= next_irq_req;
            pwm_time_base           <= next_pwm;
            spi_shift_clock         <= next_shift_toggle;
        end
    end
endmodule : pts_timer

// >>> verif/pts_far_side.sv
// Far-side model: PWM units and serial port fed by the timer
module pts_far_side (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Timer outputs
    input  wire logic        pwm_time_base,
    input  wire logic        spi_shift_clock,
    // Observations
    output logic      [15:0] pulses,
    output logic      [15:0] gap,
    output logic      [15:0] edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cyc;
    logic [15:0] last;
    logic        spi_q;
    // Count time-base periods and their length in clocks
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {cyc, last, pulses, gap, edges} <= '0;
            spi_q <= 1'b0;
        end else begin
            cyc <= cyc + 16'h0001;
            spi_q <= spi_shift_clock;
            if (pwm_time_base) begin
                pulses <= pulses + 16'h0001;
                gap <= cyc - last;
                last <= cyc;
            end
            if (spi_shift_clock != spi_q)
                edges <= edges + 16'h0001;
        end
    end
endmodule : pts_far_side

// >>> verif/pts_timer_checker.sv
// Port checker for the period timer
module pts_timer_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // APB and context
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        instr_tick,
    input wire logic        sleep,
    // Timer outputs
    input wire logic        pwm_time_base,
    input wire logic        spi_shift_clock,
    input wire logic        period_match_irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wr_hist;
    logic       next_wr_hist;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Write taken one cycle ago; request and flag fall at that same edge
    always_comb next_wr_hist = psel && penable && pwrite && !pready;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) wr_hist <= 1'b0;
        else wr_hist <= next_wr_hist;
    end
    ready_wait_a: assert property (psel && penable && !pready |=> pready) // one wait state
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) // single cycle
        else $error("pready held");
    err_with_ready_a: assert property (pslverr |-> pready) // error qualifies answer
        else $error("pslverr alone");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) // quiet bus
        else $error("prdata not zero");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) // byte wide
        else $error("prdata upper set");
    spi_toggle_a: assert property ($changed(spi_shift_clock) |-> pwm_time_base)
        else $error("shift clock moved");
    sleep_hold_a: assert property (sleep |=> !pwm_time_base)
        else $error("match in sleep");
    tick_gate_a: assert property (!instr_tick |=> !pwm_time_base)
        else $error("match without tick");
    irq_fall_a: assert property ($fell(period_match_irq_req) |-> wr_hist)
        else $error("irq dropped alone");
endmodule : pts_timer_checker
bind pts_timer pts_timer_checker pts_timer_checker_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_tick(instr_tick), .sleep(sleep), .pwm_time_base(pwm_time_base),
    .spi_shift_clock(spi_shift_clock), .period_match_irq_req(period_match_irq_req));

// >>> verif/period_timer_with_postscaler_test.sv
// Self-checking bench for the period timer
module period_timer_with_postscaler_test;
    import pts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleep = 0, instr_tick = 1, half = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, pwm_time_base, spi_shift_clock, period_match_irq_req;
    logic [15:0] pulses, gap, edges;
    int          n_mismatch = 0, n_checks = 0, cycles = 0;
    pts_timer pts_timer_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_tick(instr_tick), .sleep(sleep), .pwm_time_base(pwm_time_base),
        .spi_shift_clock(spi_shift_clock), .period_match_irq_req(period_match_irq_req));
    pts_far_side pts_far_side_inst (.core_clk(core_clk), .rst(rst), .pwm_time_base(pwm_time_base),
        .spi_shift_clock(spi_shift_clock), .pulses(pulses), .gap(gap), .edges(edges));
    always #4 core_clk = ~core_clk;
    // Half-rate instruction tick when asked, else every clock
    always @(posedge core_clk) instr_tick <= half ? ~instr_tick : 1'b1;
    // Hang guard, well above the few thousand clocks needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // APB master: hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check("read data", x, q);
        check("read error", (a > PTS_OFS_ENABLES), e);
    endtask : rd
    function automatic logic [31:0] ctl(input logic [3:0] po, input logic r, input logic [1:0] pr);
        return {24'h00_0000, 1'b0, po, r, pr};
    endfunction : ctl
    task automatic wait_pulses(input int k);
        logic [15:0] n0;
        n0 = pulses;
        while (pulses < n0 + k) @(negedge core_clk);
    endtask : wait_pulses
    task automatic t_reset();
        rd(PTS_OFS_CONTROL, 32'h0000_0000);
        rd(PTS_OFS_PERIOD, 32'h0000_00FF);
        rd(PTS_OFS_COUNT, 32'h0000_0000);
        rd(PTS_OFS_FLAGS, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
    endtask : t_reset
    // Period 3: gap is four ticks times the prescale ratio
    task automatic t_prescale();
        wr(PTS_OFS_PERIOD, 32'h0000_0003);
        for (int p = 0; p < 4; p++) begin
            wr(PTS_OFS_CONTROL, ctl(4'h0, 1'b1, 2'(p)));
            wait_pulses(3);
            check("gap", 32'(4 << (2 * p)), gap);
        end
        // Back to divide by one, so only the half-rate tick stretches the gap
        wr(PTS_OFS_CONTROL, ctl(4'h0, 1'b1, 2'b00));
        half <= 1'b1;
        wait_pulses(3);
        check("gap half tick", 32'h0000_0008, gap);
        half <= 1'b0;
    endtask : t_prescale
    // Every postscale code: matches counted up to the request
    task automatic t_post();
        logic [15:0] n0;
        wr(PTS_OFS_ENABLES, 32'h0000_0002);
        for (int c = 0; c < 16; c++) begin
            wr(PTS_OFS_CONTROL, ctl(4'(c), 1'b0, 2'b00));
            wr(PTS_OFS_FLAGS, 32'h0000_0000);
            wr(PTS_OFS_CONTROL, ctl(4'(c), 1'b1, 2'b00));
            @(negedge core_clk);
            n0 = pulses;
            while (period_match_irq_req !== 1'b1) @(negedge core_clk);
            // Last time-base pulse reaches the far side one clock after the request
            @(negedge core_clk);
            check("matches per event", c + 1, pulses - n0);
        end
        wr(PTS_OFS_ENABLES, 32'h0000_0000);
        @(negedge core_clk);
        check("masked request", 1'b0, period_match_irq_req);
        rd(PTS_OFS_FLAGS, 32'h0000_0002);
    endtask : t_post
    // Sleep, then run bit off: count must stand still
    task automatic t_hold();
        logic [31:0] a, b;
        logic        e;
        wr(PTS_OFS_PERIOD, 32'h0000_00FF);
        wr(PTS_OFS_CONTROL, ctl(4'h0, 1'b1, 2'b00));
        for (int s = 0; s < 2; s++) begin
            if (s == 0) sleep <= 1'b1;
            else wr(PTS_OFS_CONTROL, ctl(4'h0, 1'b0, 2'b00));
            apb(1'b0, PTS_OFS_COUNT, 32'h0000_0000, a, e);
            repeat (10) @(posedge core_clk);
            apb(1'b0, PTS_OFS_COUNT, 32'h0000_0000, b, e);
            check("held count", a, b);
            rd(PTS_OFS_PERIOD, 32'h0000_00FF);
            sleep <= 1'b0;
        end
    endtask : t_hold
    task automatic t_keep();
        wr(PTS_OFS_COUNT, 32'h0000_0055);
        wr(PTS_OFS_CONTROL, ctl(4'h5, 1'b0, 2'b01));
        rd(PTS_OFS_COUNT, 32'h0000_0055);
        rd(PTS_OFS_CONTROL, ctl(4'h5, 1'b0, 2'b01));
        check("shift clock edges", pulses, edges);
        // Reset with the run bit off must undo written count, period and control
        wr(PTS_OFS_PERIOD, 32'h0000_0010);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
    endtask : t_keep
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_prescale();
        t_post();
        t_hold();
        t_keep();
        final_report();
    end
endmodule : period_timer_with_postscaler_test
